// File: hw/edge_select_pkg.sv
// Package of constants and types for the serial port edge selection block.
package edge_select_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int WORD_WIDTH = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic MODE_RESET = 1'b1;
  localparam logic [WORD_WIDTH-1:0] SHIFT_RESET = 10'h000;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  // Interface mode latched at chip-select fall.
  typedef enum logic {
    MODE_SIGNAL_PROC,
    MODE_HOST_PROC
  } host_mode_type;

endpackage

// File: hw/serial_port_edge_select.sv
// Serial port edge selection with input shifter, output shifter and word FIFO.
//
// Contract
// - Input data register samples on the shift clock or its inverse.
// - Strap low inverts the input sampling clock.
// - Inversion moves sampling by half a shift-clock period for more setup.
// - With inversion, output changes on the same edge that samples input.
// - Frame sync high at chip-select fall selects host mode, low signal-processor.
// - Strap high: host mode launch fall, sample rise; other mode opposite.
// - Strap low: host mode both on fall; signal-processor mode both on rise.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Word FIFO
// ------------------------------------------------------------------
module word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [WIDTH-1:0] in_data, // Word written.
  output logic out_valid, // Word available.
  input wire logic out_ready, // Drain accepts.
  output logic [WIDTH-1:0] out_data // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // The count is one bit wider than the pointers, so that full and empty
  // stay distinct when the pointers meet.
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + AW'(1);
      if (pop) rd_reg <= rd_reg + AW'(1);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_reg[wr_reg] <= in_data;
  end
endmodule

// ------------------------------------------------------------------
// Top module
// ------------------------------------------------------------------
module serial_port_edge_select
  import edge_select_pkg::*;
(
  input wire logic CLK, // System clock, 10 MHz.
  input wire logic RSTN, // Asynchronous reset, active low.
  input wire logic SHIFT_CLK, // Serial shift clock pin.
  input wire logic CHIP_SELECT_N, // Chip select pin, active low.
  input wire logic FRAME_START_STROBE, // Frame sync pin.
  input wire logic CLOCK_INVERT_STRAP, // Strap; low inverts input sampling.
  input wire logic SERIAL_IN, // Serial data in pin.
  output logic SERIAL_OUT, // Serial data out pin.
  output logic HOST_PROCESSOR_MODE, // Latched interface mode.
  input wire logic [WORD_WIDTH-1:0] TX_DATA, // Word to shift out.
  output logic TX_LOAD, // Pulse: TX_DATA taken at chip-select fall.
  output logic RX_VALID, // Received word available.
  input wire logic RX_READY, // User accepts received word.
  output logic [WORD_WIDTH-1:0] RX_DATA // Received word.
);
  import edge_select_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // The shift clock is 800 ns, so system-clock sampling finds each edge.
  localparam int NPIN = 5;
  wire [NPIN-1:0] pin_raw = {SHIFT_CLK, CHIP_SELECT_N, FRAME_START_STROBE,
                             CLOCK_INVERT_STRAP, SERIAL_IN};
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  logic [NPIN-1:0] prev_reg;

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : gen_sync
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          sync1_reg[g] <= 1'b1;
          sync2_reg[g] <= 1'b1;
          prev_reg[g] <= 1'b1;
        end else begin
          sync1_reg[g] <= pin_raw[g];
          sync2_reg[g] <= sync1_reg[g];
          prev_reg[g] <= sync2_reg[g];
        end
      end
    end
  endgenerate

  wire sclk = sync2_reg[4];
  wire cs_n = sync2_reg[3];
  wire frame = sync2_reg[2];
  wire strap = sync2_reg[1];
  wire sdi = sync2_reg[0];
  wire sclk_rise = sclk && !prev_reg[4];
  wire sclk_fall = !sclk && prev_reg[4];
  wire cs_fall = !cs_n && prev_reg[3];

  // ----------------------------------------------------------------
  // Edge selection functions
  // ----------------------------------------------------------------
  // Output bits move on the fall in host mode and on the rise otherwise.
  function automatic logic pick_launch(input logic host, input logic rise, input logic fall);
    return host ? fall : rise;
  endfunction

  // With the strap high the input is sampled on the edge opposite the launch
  // edge; with it low the sampling clock is inverted, which lands sampling on
  // the launch edge and buys the host half a period of extra setup.
  function automatic logic pick_sample(input logic strap_high, input logic host,
                                       input logic rise, input logic fall);
    return strap_high ? (host ? rise : fall) : pick_launch(host, rise, fall);
  endfunction

  // ----------------------------------------------------------------
  // Mode latch
  // ----------------------------------------------------------------
  host_mode_type mode_reg;
  host_mode_type mode_next;
  logic fs_high_reg;
  logic fs_high_next;
  logic armed_reg;
  logic armed_next;
  logic active_reg;
  logic active_next;

  // The frame sync level at the chip-select fall picks the interface mode.
  assign mode_next = cs_fall ? (frame ? MODE_HOST_PROC : MODE_SIGNAL_PROC) : mode_reg;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_reg <= MODE_HOST_PROC;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ----------------------------------------------------------------
  // Frame start qualification
  // ----------------------------------------------------------------
  // A signal-processor frame is begun only once frame sync has been seen high
  // while deselected and then low at a chip-select fall. The two falls need
  // not share a cycle, since the host may drop frame sync first.
  wire fs_high_idle = cs_n && frame;
  wire fs_walk_done = cs_fall && !frame && fs_high_reg;
  wire start_ok = frame || armed_reg || fs_walk_done;

  assign fs_high_next = cs_fall ? 1'b0 : (fs_high_reg || fs_high_idle);
  assign armed_next = armed_reg || fs_walk_done;
  // Raising chip select ends the frame at once; a partial word is dropped.
  assign active_next = cs_n ? 1'b0 : (cs_fall ? start_ok : active_reg);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fs_high_reg <= 1'b0;
    end else begin
      fs_high_reg <= fs_high_next;
    end
  end

  // Once armed the port stays armed, so later signal-processor frames may
  // keep frame sync low across chip-select cycles.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
    end
  end

  // ----------------------------------------------------------------
  // Edge selection
  // ----------------------------------------------------------------
  wire host_mode = (mode_reg == MODE_HOST_PROC);
  wire launch_edge = pick_launch(host_mode, sclk_rise, sclk_fall);
  wire sample_edge = pick_sample(strap, host_mode, sclk_rise, sclk_fall);
  // The strap is read live; changing it inside a frame gives undefined edges.
  wire launch_now = active_reg && launch_edge;
  wire sample_now = active_reg && sample_edge;

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  logic [WORD_WIDTH-1:0] tx_shift_reg;
  logic [WORD_WIDTH-1:0] tx_shift_next;
  logic out_reg;
  logic out_next;
  logic load_reg;

  // The word is taken at the chip-select fall, so the first bit stands
  // before the first launch edge.
  assign tx_shift_next = cs_fall ? TX_DATA
                       : launch_now ? {tx_shift_reg[WORD_WIDTH-2:0], 1'b0}
                       : tx_shift_reg;
  assign out_next = cs_fall ? TX_DATA[WORD_WIDTH-1]
                  : launch_now ? tx_shift_reg[WORD_WIDTH-2]
                  : out_reg;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_shift_reg <= SHIFT_RESET;
    end else begin
      tx_shift_reg <= tx_shift_next;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= cs_fall;
    end
  end

  // ----------------------------------------------------------------
  // Input shifter
  // ----------------------------------------------------------------
  logic [WORD_WIDTH-1:0] rx_shift_reg;
  logic [WORD_WIDTH-1:0] rx_shift_next;
  logic [3:0] rx_count_reg;
  logic [3:0] rx_count_next;
  wire fifo_in_ready;
  wire [WORD_WIDTH-1:0] rx_word = {rx_shift_reg[WORD_WIDTH-2:0], sdi};
  wire word_done = sample_now && (rx_count_reg == 4'(WORD_WIDTH - 1));
  // A full FIFO drops the word; with eight words waiting, the user must drain before a ninth word completes.
  wire push = word_done && fifo_in_ready;

  assign rx_shift_next = (sample_now && !cs_fall) ? rx_word : rx_shift_reg;
  assign rx_count_next = cs_fall ? COUNT_RESET
                       : !sample_now ? rx_count_reg
                       : word_done ? COUNT_RESET
                       : rx_count_reg + 4'h1;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_shift_reg <= SHIFT_RESET;
    end else begin
      rx_shift_reg <= rx_shift_next;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_count_reg <= COUNT_RESET;
    end else begin
      rx_count_reg <= rx_count_next;
    end
  end

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  word_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clk(CLK),
    .rst_n(RSTN),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rx_word),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(RX_DATA)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SERIAL_OUT = out_reg;
  assign HOST_PROCESSOR_MODE = host_mode;
  assign TX_LOAD = load_reg;
endmodule

// File: verification/serial_port_edge_select_chk.sv
// Checker for the serial port edge selection block.
`timescale 1ns/1ps
module serial_port_edge_select_chk
  import edge_select_pkg::*;
(
  input wire logic CLK, // Clock.
  input wire logic RSTN, // Reset.
  input wire logic SHIFT_CLK, // Shift clock.
  input wire logic CHIP_SELECT_N, // Select.
  input wire logic FRAME_START_STROBE, // Frame sync.
  input wire logic CLOCK_INVERT_STRAP, // Strap.
  input wire logic SERIAL_OUT, // Data out.
  input wire logic HOST_PROCESSOR_MODE, // Mode.
  input wire logic TX_LOAD, // Load pulse.
  input wire logic RX_VALID, // Word ready.
  input wire logic RX_READY, // Pop.
  input wire logic [WORD_WIDTH-1:0] RX_DATA // Word.
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Pin edges reach the logic a few cycles late, so the clock level is looked up in the past.
  property p_tx_pulse; TX_LOAD |=> !TX_LOAD; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("load pulse too long");
  property p_tx_frame; TX_LOAD |-> !CHIP_SELECT_N; endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("load outside frame");
  property p_mode_fs; TX_LOAD |-> HOST_PROCESSOR_MODE == FRAME_START_STROBE; endproperty
  a_mode_fs: assert property (p_mode_fs) else $error("mode not frame sync");
  property p_mode_hold; !$stable(HOST_PROCESSOR_MODE) |-> TX_LOAD; endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved mid frame");
  property p_launch_hp;
    $changed(SERIAL_OUT) && !TX_LOAD && !CHIP_SELECT_N && HOST_PROCESSOR_MODE
      |-> !$past(SHIFT_CLK, 2);
  endproperty
  a_launch_hp: assert property (p_launch_hp) else $error("host launch edge");
  property p_launch_sp;
    $changed(SERIAL_OUT) && !TX_LOAD && !CHIP_SELECT_N && !HOST_PROCESSOR_MODE
      |-> $past(SHIFT_CLK, 2);
  endproperty
  a_launch_sp: assert property (p_launch_sp) else $error("dsp launch edge");
  property p_sample;
    $rose(RX_VALID) |-> $past(SHIFT_CLK, 3) == (HOST_PROCESSOR_MODE ~^ CLOCK_INVERT_STRAP);
  endproperty
  a_sample: assert property (p_sample) else $error("sample edge");
  property p_rx_hold; RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("word not held");
  c_hp_load: cover property (TX_LOAD && HOST_PROCESSOR_MODE);
  c_sp_load: cover property (TX_LOAD && !HOST_PROCESSOR_MODE);
  c_pop: cover property (RX_VALID && RX_READY);
endmodule

bind serial_port_edge_select serial_port_edge_select_chk chk (.*);

// File: verification/host_port_model.sv
// Host serial port model that frames one word and clocks it both ways.
`timescale 1ns/1ps
module host_port_model (
  output logic shift_clk, // Shift clock, still between frames.
  output logic chip_select_n, // Select, active low.
  output logic frame_start_strobe, // Frame sync.
  output logic serial_in, // Data to the device.
  input wire logic serial_out, // Data from the device.
  input wire logic strap // Strap level the device sees.
);
  initial {shift_clk, chip_select_n, frame_start_strobe, serial_in} = 4'h7;
  task automatic frame(input logic hm, input logic [9:0] d, output logic [9:0] got);
    // Pins move a quarter clock after the edge, never on it.
    #25 shift_clk = !hm;
    frame_start_strobe = 1'b1;
    #400 frame_start_strobe = hm;
    #400 chip_select_n = 1'b0;
    #1000;
    for (int i = 9; i >= 0; i--) begin
      // Data moves on the edge that does not sample, giving half a period each side.
      if (strap) serial_in = d[i];
      #400 shift_clk = hm;
      if (!strap) serial_in = d[i];
      #400 got[i] = serial_out;
      shift_clk = !hm;
    end
    #400 chip_select_n = 1'b1;
    serial_in = !serial_in;
    frame_start_strobe = 1'b1;
    #1600;
  endtask
endmodule

// File: verification/serial_port_edge_select_tb_top.sv
// Testbench for the serial port edge selection block.
`timescale 1ns/1ps
module serial_port_edge_select_tb_top;
  import edge_select_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic strap = 1'b1;
  logic rx_ready = 1'b0;
  logic [WORD_WIDTH-1:0] tx_data = 10'h000;
  logic sck, cs_n, fs, sdi, sdo, mode, tx_load, rx_valid;
  logic [WORD_WIDTH-1:0] rx_data, got;
  int num_errors = 0;
  int check_count = 0;
  always #50 clk = !clk;
  serial_port_edge_select uut (.CLK(clk), .RSTN(rstn), .SHIFT_CLK(sck), .CHIP_SELECT_N(cs_n),
    .FRAME_START_STROBE(fs), .CLOCK_INVERT_STRAP(strap), .SERIAL_IN(sdi), .SERIAL_OUT(sdo),
    .HOST_PROCESSOR_MODE(mode), .TX_DATA(tx_data), .TX_LOAD(tx_load), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_DATA(rx_data));
  host_port_model host (.shift_clk(sck), .chip_select_n(cs_n), .frame_start_strobe(fs),
    .serial_in(sdi), .serial_out(sdo), .strap(strap));
  task automatic end_sim();
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [WORD_WIDTH-1:0] exp, act);
    check_count++;
    if (act !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic frame(input logic hm, input logic [WORD_WIDTH-1:0] tx, rx);
    @(posedge clk) tx_data <= tx;
    host.frame(hm, rx, got);
    chk("serial_out word", tx, got);
    chk("mode", {9'h000, hm}, {9'h000, mode});
  endtask
  task automatic pop(input logic [WORD_WIDTH-1:0] exp);
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rx_valid !== 1'b1 && n < 3000);
    if (rx_valid !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    chk("rx word", exp, rx_data);
    rx_ready <= 1'b1;
    @(posedge clk) rx_ready <= 1'b0;
  endtask
  // Strap moves only between frames, as the host must keep it static.
  task automatic sc_edge_table();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) strap <= i[1];
      frame(i[0], 10'h2a5 ^ 10'(i), 10'h181 + 10'(i));
      pop(10'h181 + 10'(i));
    end
  endtask
  task automatic sc_fifo_full();
    for (int i = 0; i < 9; i++) frame(1'b1, 10'h3ff, 10'h200 + 10'(i));
    for (int i = 0; i < 8; i++) pop(10'h200 + 10'(i));
    repeat (4) @(posedge clk);
    chk("fifo empty", 10'h000, {9'h000, rx_valid});
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    sc_edge_table();
    sc_fifo_full();
    end_sim();
  end
endmodule
